// ===== design/acl_pkg.sv
package acl_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_DIDR  = 6'h01;
    localparam logic [5:0] IDX_CSRB  = 6'h03;
    localparam logic [5:0] IDX_CONV  = 6'h04;
    localparam logic [5:0] IDX_ISTAT = 6'h05;
    localparam logic [5:0] IDX_IMASK = 6'h06;
    localparam logic [5:0] IDX_CSR   = 6'h08;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CSR_POWER_OFF = 7;
    localparam int CSR_BANDGAP   = 6;
    localparam int CSR_RESULT    = 5;
    localparam int CSR_FLAG      = 4;
    localparam int CSR_IRQ_EN    = 3;
    localparam int CSR_CAPT      = 2;
    localparam int CSRB_MUX_EN   = 6;
    localparam int CONV_EN       = 7;
    localparam int CHAN_W        = 5;
    localparam int ISTAT_CMP     = 0;

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CSR_RST   = 8'h00;
    localparam logic [7:0] DIDR_RST  = 8'h00;
    localparam logic [7:0] CSRB_RST  = 8'h00;
    localparam logic [7:0] CONV_RST  = 8'h00;
    localparam logic [7:0] IMASK_RST = 8'h01;
    localparam logic [4:0] CHAN_LAST = 5'h07;

    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RSVD   = 2'h1;
    localparam logic [1:0] MODE_FALL   = 2'h2;
    localparam logic [1:0] MODE_RISE   = 2'h3;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       power_off;
        logic       bandgap;
        logic       irq_enable;
        logic       capture_en;
        logic [1:0] mode;
    } acl_ctrl_t;

    typedef struct packed {
        logic       use_mux;
        logic [2:0] channel;
    } acl_neg_sel_t;

endpackage

// ===== design/acl_sync.sv
module acl_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level in and out
    input  wire logic d,
    output logic      q
);

    logic meta_q;

    // first stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // acl_sync

// ===== design/acl_edge.sv
module acl_edge (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // synchronised level and mode
    input  wire logic       cur,
    input  wire logic [1:0] mode,
    // one-cycle event
    output logic            cmp_event
);

    logic prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= cur;
        end
    end

    always_comb begin
        case (mode)
            acl_pkg::MODE_TOGGLE: cmp_event = cur ^ prev_q;
            acl_pkg::MODE_FALL:   cmp_event = !cur && prev_q;
            acl_pkg::MODE_RISE:   cmp_event = cur && !prev_q;
            default:              cmp_event = 1'b0;
        endcase
    end

endmodule // acl_edge

// ===== design/acl_top.sv
module acl_top (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // comparator and processor
    input  wire logic                 cmp_raw,
    input  wire logic                 global_irq_enable,
    input  wire logic                 irq_vector_ack,
    output logic                      irq,
    // analog routing
    output logic                      comparator_power_off,
    output logic                      bandgap_select,
    output acl_pkg::acl_neg_sel_t     neg_sel,
    output logic                      capture_trigger,
    // pins
    input  wire logic [7:0]           pin_in,
    output logic [7:0]                buffer_off,
    output logic [7:0]                pin_read
);

    // ------------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------------
    acl_pkg::acl_ctrl_t ctrl_q;
    logic               flag_q;
    logic [7:0]         didr_q;
    logic [7:0]         csrb_q;
    logic [7:0]         conv_q;
    logic [7:0]         imask_q;
    logic               result;
    logic               cmp_event;
    logic               wr;
    logic               wr_csr;
    logic               wr_istat;
    logic               flag_clr;
    logic               mux_en;
    logic               conv_en;
    logic [4:0]         chan;
    logic [7:0]         rd_byte;
    logic               hit;

    function automatic logic sel_is(input logic [7:0] a,
                                    input logic [5:0] idx);
        sel_is = (a == {idx, 2'b00});
    endfunction

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = sel_is(a, acl_pkg::IDX_DIDR)
                 | sel_is(a, acl_pkg::IDX_CSRB)
                 | sel_is(a, acl_pkg::IDX_CONV)
                 | sel_is(a, acl_pkg::IDX_ISTAT)
                 | sel_is(a, acl_pkg::IDX_IMASK)
                 | sel_is(a, acl_pkg::IDX_CSR);
    endfunction

    // zero wait states: data was captured in the setup cycle
    assign pready   = 1'b1;
    assign hit      = addr_hit(paddr);
    assign pslverr  = psel && penable && !hit;
    assign wr       = psel && penable && pwrite && hit;
    assign wr_csr   = wr && sel_is(paddr, acl_pkg::IDX_CSR);
    assign wr_istat = wr && sel_is(paddr, acl_pkg::IDX_ISTAT);

    assign mux_en  = csrb_q[acl_pkg::CSRB_MUX_EN];
    assign conv_en = conv_q[acl_pkg::CONV_EN];
    assign chan    = conv_q[acl_pkg::CHAN_W-1:0];

    // ------------------------------------------------------------------
    // comparator result path
    // ------------------------------------------------------------------
    acl_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (cmp_raw),
        .q       (result)
    );

    acl_edge u_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .cur       (result),
        .mode      (ctrl_q.mode),
        .cmp_event (cmp_event)
    );

    // ------------------------------------------------------------------
    // control/status register
    // ------------------------------------------------------------------
    // result bit is not stored here, so writes to it fall away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= acl_pkg::acl_ctrl_t'({acl_pkg::CSR_RST[7:6],
                                            acl_pkg::CSR_RST[3:0]});
        end else if (wr_csr) begin
            ctrl_q.power_off  <= pwdata[acl_pkg::CSR_POWER_OFF];
            ctrl_q.bandgap    <= pwdata[acl_pkg::CSR_BANDGAP];
            ctrl_q.irq_enable <= pwdata[acl_pkg::CSR_IRQ_EN];
            ctrl_q.capture_en <= pwdata[acl_pkg::CSR_CAPT];
            ctrl_q.mode       <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // interrupt flag
    // ------------------------------------------------------------------
    // a clear in the same cycle as an event loses to the event
    assign flag_clr = irq_vector_ack
                    | (wr_csr && pwdata[acl_pkg::CSR_FLAG])
                    | (wr_istat && pwdata[acl_pkg::ISTAT_CMP]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= cmp_event | (flag_q & !flag_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= acl_pkg::IMASK_RST;
        end else if (wr && sel_is(paddr, acl_pkg::IDX_IMASK)) begin
            imask_q <= {7'h00, pwdata[acl_pkg::ISTAT_CMP]};
        end
    end

    // mask defaults open so the enable bit and global_irq_enable alone gate the request
    assign irq = flag_q && ctrl_q.irq_enable && global_irq_enable
              && imask_q[acl_pkg::ISTAT_CMP];

    // ------------------------------------------------------------------
    // converter-side registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csrb_q <= acl_pkg::CSRB_RST;
        end else if (wr && sel_is(paddr, acl_pkg::IDX_CSRB)) begin
            csrb_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_q <= acl_pkg::CONV_RST;
        end else if (wr && sel_is(paddr, acl_pkg::IDX_CONV)) begin
            conv_q <= {pwdata[acl_pkg::CONV_EN], 2'h0,
                       pwdata[acl_pkg::CHAN_W-1:0]};
        end
    end

    // ------------------------------------------------------------------
    // negative input selection
    // ------------------------------------------------------------------
    // codes above channel 7 fall back to the dedicated pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_sel <= '0;
        end else if (mux_en && !conv_en
                     && chan <= acl_pkg::CHAN_LAST) begin
            neg_sel.use_mux <= 1'b1;
            neg_sel.channel <= chan[2:0];
        end else begin
            neg_sel.use_mux <= 1'b0;
            neg_sel.channel <= 3'h0;
        end
    end

    // ------------------------------------------------------------------
    // analog controls and pins
    // ------------------------------------------------------------------
    assign comparator_power_off = ctrl_q.power_off;
    assign bandgap_select       = ctrl_q.bandgap;
    assign capture_trigger      = result && ctrl_q.capture_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            didr_q <= acl_pkg::DIDR_RST;
        end else if (wr && sel_is(paddr, acl_pkg::IDX_DIDR)) begin
            didr_q <= pwdata[7:0];
        end
    end

    assign buffer_off = didr_q;
    assign pin_read   = pin_in & ~didr_q;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (sel_is(paddr, acl_pkg::IDX_CSR)) begin
            rd_byte = {ctrl_q.power_off, ctrl_q.bandgap, result,
                       flag_q, ctrl_q.irq_enable, ctrl_q.capture_en,
                       ctrl_q.mode};
        end else if (sel_is(paddr, acl_pkg::IDX_DIDR)) begin
            rd_byte = didr_q;
        end else if (sel_is(paddr, acl_pkg::IDX_CSRB)) begin
            rd_byte = csrb_q;
        end else if (sel_is(paddr, acl_pkg::IDX_CONV)) begin
            rd_byte = conv_q;
        end else if (sel_is(paddr, acl_pkg::IDX_ISTAT)) begin
            rd_byte = {7'h00, flag_q};
        end else if (sel_is(paddr, acl_pkg::IDX_IMASK)) begin
            rd_byte = imask_q;
        end
    end

    // sampled in the setup cycle, held through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_result_lag: assert property (
        ##2 result == $past(cmp_raw, 2)
    ) else $error("result does not lag raw by two edges");

    a_rise_flag: assert property (
        (ctrl_q.mode == acl_pkg::MODE_RISE && $rose(result))
        |=> flag_q
    ) else $error("rising edge did not set flag");

    a_fall_only: assert property (
        (ctrl_q.mode == acl_pkg::MODE_FALL && $rose(result)
         && !flag_q) |=> !flag_q
    ) else $error("rising edge set flag in fall mode");

    a_rsvd_quiet: assert property (
        (ctrl_q.mode == acl_pkg::MODE_RSVD && !flag_q) |=> !flag_q
    ) else $error("reserved mode set the flag");

    a_ack_clears: assert property (
        (irq_vector_ack && !cmp_event) |=> !flag_q
    ) else $error("vector ack did not clear flag");

    a_zero_keeps: assert property (
        (flag_q && !irq_vector_ack && !wr_istat && wr_csr
         && !pwdata[acl_pkg::CSR_FLAG]) |=> flag_q
    ) else $error("writing zero cleared flag");

    a_irq_gated: assert property (
        irq |-> (flag_q && ctrl_q.irq_enable && global_irq_enable)
    ) else $error("irq without flag and enables");

    a_power_write: assert property (
        wr_csr |=> comparator_power_off
                   == $past(pwdata[acl_pkg::CSR_POWER_OFF])
    ) else $error("power-off bit did not follow write");

    a_mux_route: assert property (
        (mux_en && !conv_en && chan <= acl_pkg::CHAN_LAST)
        |=> (neg_sel.use_mux && neg_sel.channel == $past(chan[2:0]))
    ) else $error("mux channel not routed");

    a_pin_route: assert property (
        (!mux_en || conv_en) |=> !neg_sel.use_mux
    ) else $error("negative pin not selected");

    a_capture_off: assert property (
        !ctrl_q.capture_en |-> !capture_trigger
    ) else $error("capture driven while disabled");

    a_pin_zero: assert property (
        (pin_read & buffer_off) == 8'h00
    ) else $error("disabled pin reads one");

    a_fall_flag: assert property (
        (ctrl_q.mode == acl_pkg::MODE_FALL && $fell(result)) |=> flag_q
    ) else $error("falling edge did not set flag");

    a_toggle_flag: assert property (
        (ctrl_q.mode == acl_pkg::MODE_TOGGLE && $changed(result)) |=> flag_q
    ) else $error("toggle did not set flag");

    a_w1c_clears: assert property (
        (flag_q && wr_csr && pwdata[acl_pkg::CSR_FLAG] && !cmp_event)
        |=> !flag_q
    ) else $error("writing one did not clear flag");

    a_istat_clear: assert property (
        (flag_q && wr_istat && pwdata[acl_pkg::ISTAT_CMP] && !cmp_event)
        |=> !flag_q
    ) else $error("status write did not clear flag");

    a_irq_raised: assert property (
        (flag_q && ctrl_q.irq_enable && global_irq_enable
         && imask_q[acl_pkg::ISTAT_CMP]) |-> irq
    ) else $error("irq missing with flag and enables");

    a_mode_write: assert property (
        wr_csr |=> ctrl_q.mode == $past(pwdata[1:0])
    ) else $error("mode field did not follow write");

    a_pwr_keep: assert property (
        !wr_csr |=> $stable(comparator_power_off)
    ) else $error("power-off bit changed without write");

    a_bandgap_write: assert property (
        wr_csr |=> bandgap_select == $past(pwdata[acl_pkg::CSR_BANDGAP])
    ) else $error("bandgap select did not follow write");

    a_capture_on: assert property (
        ctrl_q.capture_en |-> capture_trigger == result
    ) else $error("capture does not follow result");

    a_csrb_write: assert property (
        (wr && sel_is(paddr, acl_pkg::IDX_CSRB))
        |=> mux_en == $past(pwdata[acl_pkg::CSRB_MUX_EN])
    ) else $error("mux enable did not follow write");

    a_result_read: assert property (
        (psel && !penable && sel_is(paddr, acl_pkg::IDX_CSR))
        |=> prdata[acl_pkg::CSR_RESULT] == $past(result)
    ) else $error("result bit not read back");

    a_didr_write: assert property (
        (wr && sel_is(paddr, acl_pkg::IDX_DIDR))
        |=> buffer_off == $past(pwdata[7:0])
    ) else $error("input disable did not follow write");

    a_event_edge: assert property (
        cmp_event |-> $changed(result)
    ) else $error("event without result change");

endmodule // acl_top

// ===== testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  cmp_raw;
    logic                  global_irq_enable;
    logic                  irq_vector_ack;
    logic                  irq;
    logic                  comparator_power_off;
    logic                  bandgap_select;
    acl_pkg::acl_neg_sel_t neg_sel;
    logic                  capture_trigger;
    logic [7:0]            pin_in;
    logic [7:0]            buffer_off;
    logic [7:0]            pin_read;
    int                    err_total;
    int                    compares;
    logic [31:0]           rdata;
    logic                  rerr;
    logic [1:0]            md;
    logic [7:0]            pv [4];

    acl_top u_dut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .cmp_raw              (cmp_raw),
        .global_irq_enable    (global_irq_enable),
        .irq_vector_ack       (irq_vector_ack),
        .irq                  (irq),
        .comparator_power_off (comparator_power_off),
        .bandgap_select       (bandgap_select),
        .neg_sel              (neg_sel),
        .capture_trigger      (capture_trigger),
        .pin_in               (pin_in),
        .buffer_off           (buffer_off),
        .pin_read             (pin_read)
    );

    always #5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; ends one idle edge later so the next can start
    task automatic apb_xfer(input logic wr, input logic [5:0] idx,
                            input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb_xfer(1'b1, idx, d);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        apb_xfer(1'b0, idx, 8'h00);
        chk_val(rdata, {24'h000000, exp});
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // watchdog: whole sequence needs well under 2000 cycles
    // ------------------------------------------------------------------
    initial begin
        #200000;
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        cmp_raw = 1'b0;
        global_irq_enable = 1'b1;
        irq_vector_ack = 1'b0;
        pin_in = 8'h00;
        err_total = 0;
        compares = 0;
        pv = '{8'h80, 8'h40, 8'hc0, 8'h00};
        tick(20);
        presetn <= 1'b1;
        tick(1);

        rd_chk(acl_pkg::IDX_CSR, 8'h00);
        rd_chk(acl_pkg::IDX_DIDR, 8'h00);
        rd_chk(acl_pkg::IDX_CSRB, 8'h00);
        rd_chk(acl_pkg::IDX_CONV, 8'h00);
        rd_chk(acl_pkg::IDX_ISTAT, 8'h00);
        rd_chk(acl_pkg::IDX_IMASK, 8'h01);
        apb_xfer(1'b0, 6'h3f, 8'h00);
        chk_bit(rerr, 1'b1);
        chk_val(rdata, 32'h00000000);
        $display("test reset done");

        // every mode against one rising and one falling edge
        for (int m = 0; m < 4; m++) begin
            md = m[1:0];
            wr(acl_pkg::IDX_CSR, {6'h04, md});
            cmp_raw <= 1'b1;
            tick(4);
            rd_chk(acl_pkg::IDX_CSR, {3'b001, md == 0 || md == 3, 2'b00, md});
            wr(acl_pkg::IDX_CSR, {6'h04, md});
            rd_chk(acl_pkg::IDX_CSR, {6'h08, md});
            cmp_raw <= 1'b0;
            tick(4);
            rd_chk(acl_pkg::IDX_CSR, {3'b000, md == 0 || md == 2, 2'b00, md});
            wr(acl_pkg::IDX_CSR, {6'h04, md});
        end
        $display("test modes done");

        wr(acl_pkg::IDX_CSR, 8'h03);
        cmp_raw <= 1'b1;
        tick(4);
        chk_bit(irq, 1'b0);
        wr(acl_pkg::IDX_CSR, 8'h0b);
        chk_bit(irq, 1'b1);
        wr(acl_pkg::IDX_CSR, 8'h0b);
        chk_bit(irq, 1'b1);
        rd_chk(acl_pkg::IDX_ISTAT, 8'h01);
        global_irq_enable <= 1'b0;
        tick(1);
        chk_bit(irq, 1'b0);
        global_irq_enable <= 1'b1;
        wr(acl_pkg::IDX_IMASK, 8'h00);
        chk_bit(irq, 1'b0);
        wr(acl_pkg::IDX_IMASK, 8'h01);
        chk_bit(irq, 1'b1);
        wr(acl_pkg::IDX_ISTAT, 8'h01);
        chk_bit(irq, 1'b0);
        cmp_raw <= 1'b0;
        tick(4);
        chk_bit(irq, 1'b0);
        cmp_raw <= 1'b1;
        tick(4);
        chk_bit(irq, 1'b1);
        irq_vector_ack <= 1'b1;
        tick(1);
        irq_vector_ack <= 1'b0;
        tick(1);
        chk_bit(irq, 1'b0);
        wr(acl_pkg::IDX_CSR, 8'h03);
        cmp_raw <= 1'b0;
        tick(4);
        $display("test interrupt done");

        for (int i = 0; i < 4; i++) begin
            wr(acl_pkg::IDX_CSR, pv[i]);
            chk_bit(comparator_power_off, pv[i][7]);
            chk_bit(bandgap_select, pv[i][6]);
            rd_chk(acl_pkg::IDX_CSR, pv[i]);
        end
        wr(acl_pkg::IDX_CSR, 8'h20);
        rd_chk(acl_pkg::IDX_CSR, 8'h00);
        $display("test power done");

        wr(acl_pkg::IDX_CSR, 8'h04);
        cmp_raw <= 1'b1;
        tick(1);
        chk_bit(capture_trigger, 1'b0);
        tick(2);
        chk_bit(capture_trigger, 1'b1);
        wr(acl_pkg::IDX_CSR, 8'h00);
        chk_bit(capture_trigger, 1'b0);
        rd_chk(acl_pkg::IDX_CSR, 8'h30);
        $display("test capture done");

        wr(acl_pkg::IDX_CSRB, 8'h40);
        rd_chk(acl_pkg::IDX_CSRB, 8'h40);
        for (int c = 0; c < 9; c++) begin
            wr(acl_pkg::IDX_CONV, 8'(c));
            tick(1);
            if (c < 8) begin
                chk_val({28'h0000000, neg_sel}, {29'h0000001, c[2:0]});
            end else begin
                chk_bit(neg_sel.use_mux, 1'b0);
            end
        end
        wr(acl_pkg::IDX_CONV, 8'h83);
        tick(1);
        chk_bit(neg_sel.use_mux, 1'b0);
        wr(acl_pkg::IDX_CONV, 8'h03);
        tick(1);
        chk_bit(neg_sel.use_mux, 1'b1);
        wr(acl_pkg::IDX_CSRB, 8'h00);
        tick(1);
        chk_bit(neg_sel.use_mux, 1'b0);
        $display("test negative input done");

        pin_in <= 8'hff;
        wr(acl_pkg::IDX_DIDR, 8'h06);
        rd_chk(acl_pkg::IDX_DIDR, 8'h06);
        chk_val({24'h000000, buffer_off}, 32'h00000006);
        chk_val({24'h000000, pin_read}, 32'h000000f9);
        pin_in <= 8'h5a;
        tick(1);
        chk_val({24'h000000, pin_read}, 32'h00000058);
        $display("test input disable done");

        final_report();
    end

endmodule // tb
